//--- logic/ext_bus_ctrl.sv
// Purpose: External bus cycle sequencer with ready handshake and bus release.
// Assumes: Software sets the control word over AXI4-Lite before any cycle.
// Notes: Strobe and arbitration pins are registered, one cycle after state.
//
// What this block does
// - Software selects ready input active polarity.
// - Asynchronous ready passes an extra synchronizer.
// - First sample point follows programmed phase lengths.
// - Inactive ready inserts a wait, resamples.
// - Active ready at sample ends cycle.
// - Sample points differ between sync and async.
// - Ready ignored until mandatory access waits elapse.
// - Arbitration enabled: release bus on hold request.
// - Finish running cycle before granting the bus.
// - Release: drive inactive, then float; latch low.
// - Regain: drive inactive before new cycles; latch low.
// - Regain request only while release acknowledged.
// - Regain starts only when hold is withdrawn.
// - Access length may be governed by ready.
`default_nettype none
module ext_bus_ctrl
	import ext_bus_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	// AXI4-Lite slave.
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Internal cycle request port.
	input wire logic cyc_req,
	input wire logic cyc_write,
	output logic cyc_done,
	// External pins.
	input wire logic ready_in,
	input wire logic hold_req_n,
	output logic release_acknowledge_n,
	output logic bus_regain_request_n,
	output logic bus_reference_clock_out,
	output logic ale,
	output logic rd_n_o,
	output logic rd_n_oe,
	output logic wr_n_o,
	output logic wr_n_oe
);
	typedef enum {C_IDLE, C_ADDR, C_CMD, C_DATA, C_ACC, C_HOLD} cyc_e;
	typedef enum {A_OWN, A_DRIVE_OFF, A_FLOAT, A_DRIVE_ON} arb_e;

	cyc_e cyc_q;
	arb_e arb_q;
	logic [31:0] ctrl_q;
	logic [3:0] aw_addr_q;
	logic aw_have_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic w_have_q;
	logic [5:0] cnt_q;
	logic [7:0] wait_cnt_q;
	logic write_q;
	logic ready_sync;
	logic ready_async;
	logic hold_sync_n;
	logic ready_level;
	logic ready_active;
	logic hold_active;
	logic start_ok;
	logic [1:0] addr_len;
	logic [1:0] cmd_len;
	logic data_len;
	logic [4:0] access_phase_length;
	logic [1:0] hold_len;
	logic [5:0] acc_load;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------

	// Normal path: two stages, as for any pin.
	sync_chain #(.STAGES(SYNC_STAGES)) ready_sync_i (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.pin_in(ready_in),
		.level_out(ready_sync)
	);

	sync_chain #(.STAGES(ASYNC_STAGES)) ready_async_i (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.pin_in(ready_in),
		.level_out(ready_async)
	);

	// The hold pin comes from another master with its own timing.
	sync_chain #(.STAGES(SYNC_STAGES)) hold_sync_i (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.pin_in(hold_req_n),
		.level_out(hold_sync_n)
	);

	// Field extraction and ready interpretation.
	assign addr_len = ctrl_q[ADDR_LEN_LSB +: 2];
	assign cmd_len = ctrl_q[CMD_LEN_LSB +: 2];
	assign data_len = ctrl_q[DATA_LEN_BIT];
	assign access_phase_length = ctrl_q[ACC_LEN_LSB +: 5];
	assign hold_len = ctrl_q[HOLD_LEN_LSB +: 2];
	assign ready_level = ctrl_q[ASYNC_BIT] ? ready_async : ready_sync;
	assign ready_active = ready_level == ctrl_q[READY_POL_BIT];
	assign hold_active = ctrl_q[ARB_EN_BIT] && !hold_sync_n;
	assign start_ok = (arb_q == A_OWN) && !hold_active && cyc_req;
	assign acc_load = {1'b0, access_phase_length} + {5'h00, ctrl_q[ASYNC_BIT]};

	// ------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------

	// Address and data are taken independently, each held until the response.
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready = !w_have_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// Capture write address and data; clear both once the response is sent.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (s_axi_bvalid && s_axi_bready) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (s_axi_bvalid && s_axi_bready) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// Commit the write and raise the response once both halves are in.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= CTRL_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (s_axi_bvalid) begin
			if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end else if (aw_have_q && w_have_q) begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr_q[3:2] == CTRL_OFFSET[3:2]) begin
				for (int i = 0; i < 4; i++) begin
					if (w_strb_q[i]) begin
						ctrl_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
					end
				end
				s_axi_bresp <= RESP_OKAY;
			end else begin
				s_axi_bresp <= RESP_SLVERR;
			end
		end
	end

	// Reads answer one cycle after the address is taken; unmapped reads zero.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else if (s_axi_arvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			if (s_axi_araddr[3:2] == CTRL_OFFSET[3:2]) begin
				s_axi_rdata <= ctrl_q;
			end else if (s_axi_araddr[3:2] == STATUS_OFFSET[3:2]) begin
				s_axi_rdata[OWNED_BIT] <= arb_q == A_OWN;
				s_axi_rdata[FLOATING_BIT] <= arb_q == A_FLOAT;
				s_axi_rdata[BUSY_BIT] <= cyc_q != C_IDLE;
				s_axi_rdata[WAIT_CNT_LSB +: 8] <= wait_cnt_q;
			end else begin
				s_axi_rresp <= RESP_SLVERR;
			end
		end
	end

	// ------------------------------------------------------------------
	// Bus cycle sequencer
	// ------------------------------------------------------------------

	// Phases run address, command delay, data setup, access, hold.
	// Zero-length command, data and hold phases are skipped; an address length of zero wraps to 64 cycles.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cyc_q <= C_IDLE;
			cnt_q <= 6'h00;
			write_q <= 1'b0;
			wait_cnt_q <= 8'h00;
			cyc_done <= 1'b0;
		end else begin
			cyc_done <= 1'b0;
			cnt_q <= cnt_q - 6'h01;
			case (cyc_q)
				C_IDLE: begin
					if (start_ok) begin
						cyc_q <= C_ADDR;
						write_q <= cyc_write;
						wait_cnt_q <= 8'h00;
						cnt_q <= {4'h0, addr_len} - 6'h01;
					end
				end
				C_ADDR: begin
					if (cnt_q == 6'h00) begin
						if (cmd_len != 2'h0) begin
							cyc_q <= C_CMD;
							cnt_q <= {4'h0, cmd_len} - 6'h01;
						end else if (data_len) begin
							cyc_q <= C_DATA;
							cnt_q <= 6'h00;
						end else begin
							cyc_q <= C_ACC;
							cnt_q <= acc_load;
						end
					end
				end
				C_CMD: begin
					if (cnt_q == 6'h00) begin
						if (data_len) begin
							cyc_q <= C_DATA;
							cnt_q <= 6'h00;
						end else begin
							cyc_q <= C_ACC;
							cnt_q <= acc_load;
						end
					end
				end
				C_DATA: begin
					cyc_q <= C_ACC;
					cnt_q <= acc_load;
				end
				C_ACC: begin
					if (cnt_q != 6'h00) begin
						cyc_q <= C_ACC;
					end else if (ctrl_q[READY_EN_BIT] && !ready_active) begin
						cnt_q <= 6'h00;
						wait_cnt_q <= wait_cnt_q + 8'h01;
					end else if (hold_len != 2'h0) begin
						cyc_q <= C_HOLD;
						cnt_q <= {4'h0, hold_len} - 6'h01;
					end else begin
						cyc_q <= C_IDLE;
						cyc_done <= 1'b1;
					end
				end
				C_HOLD: begin
					if (cnt_q == 6'h00) begin
						cyc_q <= C_IDLE;
						cyc_done <= 1'b1;
					end
				end
				default: begin
					cyc_q <= C_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Bus arbitration
	// ------------------------------------------------------------------

	// The bus is only given away from idle, and never in the cycle a new
	// one would start, since start_ok already excludes an active hold.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			arb_q <= A_OWN;
		end else begin
			case (arb_q)
				A_OWN: begin
					if (hold_active && cyc_q == C_IDLE) begin
						arb_q <= A_DRIVE_OFF;
					end
				end
				A_DRIVE_OFF: begin
					arb_q <= A_FLOAT;
				end
				A_FLOAT: begin
					if (hold_sync_n) begin
						arb_q <= A_DRIVE_ON;
					end
				end
				A_DRIVE_ON: begin
					arb_q <= A_OWN;
				end
				default: begin
					arb_q <= A_OWN;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------

	// Registered from state so pins change cleanly one cycle after it.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ale <= 1'b0;
			rd_n_o <= 1'b1;
			wr_n_o <= 1'b1;
			rd_n_oe <= 1'b1;
			wr_n_oe <= 1'b1;
			release_acknowledge_n <= 1'b1;
			bus_regain_request_n <= 1'b1;
		end else begin
			// Latch strobe only in the address phase, low while released.
			ale <= cyc_q == C_ADDR;
			rd_n_o <= !(cyc_q == C_ACC && !write_q);
			wr_n_o <= !(cyc_q == C_ACC && write_q);
			rd_n_oe <= arb_q != A_FLOAT;
			wr_n_oe <= arb_q != A_FLOAT;
			release_acknowledge_n <= arb_q != A_FLOAT;
			bus_regain_request_n <= !(arb_q == A_FLOAT && cyc_req);
		end
	end

	// Reference clock out runs at half ref_clk; ready in sync mode
	// is expected to be timed against it.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_reference_clock_out <= 1'b0;
		end else begin
			bus_reference_clock_out <= !bus_reference_clock_out;
		end
	end
endmodule
`default_nettype wire

//--- logic/ext_bus_pkg.sv
// Purpose: Shared constants for the external bus ready and arbitration block.
// Assumes: AXI4-Lite register access with 32-bit data, one word per register.
// Notes: Phase lengths are counted in ref_clk cycles.
`default_nettype none
package ext_bus_pkg;
	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam logic [3:0] ADDR_OFFSET = 4'h8;

	// ------------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------------
	localparam int READY_POL_BIT = 0;
	localparam int ASYNC_BIT = 1;
	localparam int READY_EN_BIT = 2;
	localparam int ARB_EN_BIT = 3;
	localparam int ADDR_LEN_LSB = 8;
	localparam int CMD_LEN_LSB = 12;
	localparam int DATA_LEN_BIT = 16;
	localparam int ACC_LEN_LSB = 20;
	localparam int HOLD_LEN_LSB = 28;

	// ------------------------------------------------------------------
	// Status field positions
	// ------------------------------------------------------------------
	localparam int OWNED_BIT = 0;
	localparam int FLOATING_BIT = 1;
	localparam int BUSY_BIT = 2;
	localparam int WAIT_CNT_LSB = 8;

	// ------------------------------------------------------------------
	// Reset values and responses
	// ------------------------------------------------------------------
	localparam logic [31:0] CTRL_RESET = 32'h0000_0101;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int SYNC_STAGES = 2;
	localparam int ASYNC_STAGES = 3;
endpackage
`default_nettype wire

//--- logic/sync_chain.sv
// Purpose: Flip-flop chain that brings a pin level into the ref_clk domain.
// Assumes: The input may change at any time relative to ref_clk.
// Notes: The first stage is read only by the next stage.
`default_nettype none
module sync_chain #(
	parameter int STAGES = 2
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic pin_in,
	output logic level_out
);
	logic [STAGES-1:0] chain_q;

	// Shift the pin level through the chain; resets to low.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			chain_q <= '0;
		end else begin
			chain_q <= {chain_q[STAGES-2:0], pin_in};
		end
	end

	assign level_out = chain_q[STAGES-1];
endmodule
`default_nettype wire

//--- test/ext_bus_far.sv
// Purpose: Peripheral and external master beside the bus sequencer.
// Assumes: Strobe inputs already carry the pull-up level when floated.
// Notes: Ready comes a set number of cycles into the strobe.
`default_nettype none
module ext_bus_far (
	input wire logic ref_clk,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic act_high,
	input wire logic [3:0] dly,
	input wire logic hold_want,
	output logic ready_in,
	output logic hold_req_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q = 4'h0;
	logic rdy_q = 1'h0;
	logic hold_q = 1'h0;
	// ------------------------------------------------------------
	// Ready responder
	// ------------------------------------------------------------
	// edge aligned, held
	always_ff @(posedge ref_clk) begin
		if (rd_n && wr_n) begin
			cnt_q <= 4'h0;
			rdy_q <= 1'h0;
		end else if (cnt_q == dly) begin
			rdy_q <= 1'h1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
	assign ready_in = rdy_q ~^ act_high;
	always_ff @(posedge ref_clk) begin
		hold_q <= hold_want;
	end
	assign hold_req_n = !hold_q;
endmodule
`default_nettype wire

//--- test/ext_bus_sva.sv
// Purpose: Pin checks for the external bus sequencer.
// Assumes: One clock domain with an active high reset.
// Notes: Bound to every sequencer at the foot of this file.
`default_nettype none
module ext_bus_sva (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic hold_req_n,
	input wire logic cyc_done,
	input wire logic release_acknowledge_n,
	input wire logic bus_regain_request_n,
	input wire logic ale,
	input wire logic rd_n_o,
	input wire logic rd_n_oe,
	input wire logic wr_n_o,
	input wire logic wr_n_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Pin relations
	// ------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Most relations tie a pin change to its cause, so a change without its cause shows up.
	// A hold phase may sit between strobe end and done, so allow up to two cycles.
	a_done_ends_strobe: assert property (($rose(rd_n_o) || $rose(wr_n_o)) |-> ##[0:2] (cyc_done || $past(cyc_done)))
		else $error("strobe ended without done");
	a_idle_after_done: assert property (cyc_done |-> ##1 (rd_n_o && wr_n_o))
		else $error("strobe active after done");
	a_off_then_float: assert property ($fell(rd_n_oe) |-> $past(rd_n_o) && $past(wr_n_o))
		else $error("strobe floated while active");
	a_latch_low_float: assert property (!rd_n_oe || !wr_n_oe |-> !ale)
		else $error("latch strobe high while floated");
	a_regain_inactive: assert property ($rose(rd_n_oe) |-> (rd_n_o && wr_n_o) ##1 (rd_n_o && wr_n_o))
		else $error("strobe active at regain");
	a_request_after_ack: assert property ($fell(bus_regain_request_n) |-> !release_acknowledge_n)
		else $error("regain request before acknowledge");
	a_no_cycle_granted: assert property (!release_acknowledge_n |-> rd_n_o && wr_n_o && !ale)
		else $error("cycle while bus granted");
	a_ack_needs_hold: assert property ($fell(release_acknowledge_n) |-> !$past(hold_req_n, 2))
		else $error("acknowledge without hold");
	a_regain_on_drop: assert property ($rose(release_acknowledge_n) |-> $past(hold_req_n))
		else $error("regain while hold active");
	a_float_is_acked: assert property ($fell(rd_n_oe) |-> !release_acknowledge_n)
		else $error("float without acknowledge");
endmodule
bind ext_bus_ctrl ext_bus_sva chk (.ref_clk, .sys_rst, .hold_req_n, .cyc_done,
	.release_acknowledge_n, .bus_regain_request_n, .ale, .rd_n_o, .rd_n_oe, .wr_n_o, .wr_n_oe);
`default_nettype wire

//--- test/tb_ext_bus_ready_and_arbitration.sv
// Purpose: Self-checking bench for the external bus sequencer.
// Assumes: 20 MHz ref_clk; strobe pins pulled high while floated.
// Notes: Reset and register cases first, then table rows, then arbitration cases.
`default_nettype none
module tb_ext_bus_ready_and_arbitration
	import ext_bus_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [31:0] ctrl; logic w; logic [3:0] dly; logic [7:0] base;} row_s;
	logic ref_clk = 1'h0, sys_rst = 1'h1, cyc_req = 1'h0, cyc_write = 1'h0, cyc_done;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, dly = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, ready_in, hold_req_n, release_acknowledge_n, bus_regain_request_n;
	logic bus_reference_clock_out, ale, rd_n_o, rd_n_oe, wr_n_o, wr_n_oe;
	logic act_high = 1'h1, hold_want = 1'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int miscompares = 0, checks_done = 0, len;
	wire rd_w = rd_n_oe ? rd_n_o : 1'h1;
	wire wr_w = wr_n_oe ? wr_n_o : 1'h1;
	row_s rows [6] = '{'{32'h0000_0101, 1'h0, 4'h0, 8'h03}, '{32'h2071_1205, 1'h1, 4'h0, 8'h0f},
		'{32'h2071_1207, 1'h0, 4'h0, 8'h10}, '{32'h0070_0106, 1'h1, 4'h0, 8'h0b},
		'{32'h0000_0105, 1'h0, 4'h5, 8'h03}, '{32'h0000_0106, 1'h1, 4'h5, 8'h04}};
	ext_bus_ctrl uut (.*);
	ext_bus_far far (.ref_clk, .rd_n(rd_w), .wr_n(wr_w), .act_high, .dly, .hold_want,
		.ready_in, .hold_req_n);
	// Free-running 50 ns clock.
	always #25 ref_clk = ~ref_clk;
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// A wait that runs out of cycles ends the run as a mismatch.
	task automatic bound(input int n);
		if (n > 300) begin
			check(32'h0, 32'h1);
			finish_test;
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge ref_clk);
		{s_axi_awaddr, s_axi_wdata} <= {a, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge ref_clk);
			n++;
			bound(n);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		check(s_axi_bresp, er);
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge ref_clk);
			n++;
			bound(n);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		d = s_axi_rdata;
		check(s_axi_rresp, er);
	endtask
	// Done is caught at the falling edge so the request is low before a restart.
	task automatic bus_cyc(input logic w);
		@(posedge ref_clk);
		{cyc_req, cyc_write} <= {1'h1, w};
		len = 0;
		do begin
			@(negedge ref_clk);
			len++;
			bound(len);
		end while (cyc_done !== 1'h1);
		cyc_req <= 1'h0;
	endtask
	task automatic wait_ack(input logic v);
		int n;
		n = 0;
		while (release_acknowledge_n !== v) begin
			@(negedge ref_clk);
			n++;
			bound(n);
		end
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		check({release_acknowledge_n, bus_regain_request_n, ale, rd_n_oe, rd_n_o}, 5'h1b);
		sys_rst <= 1'h0;
		axi_rd(CTRL_OFFSET, RESP_OKAY);
		check(d, CTRL_RESET);
		axi_wr(STATUS_OFFSET, 32'hffff_ffff, RESP_SLVERR);
		axi_wr(ADDR_OFFSET, 32'h0, RESP_SLVERR);
		axi_rd(ADDR_OFFSET, RESP_SLVERR);
		check(d, 32'h0);
		foreach (rows[i]) begin
			axi_wr(CTRL_OFFSET, rows[i].ctrl, RESP_OKAY);
			{act_high, dly} <= {rows[i].ctrl[0], rows[i].dly};
			bus_cyc(rows[i].w);
			axi_rd(STATUS_OFFSET, RESP_OKAY);
			check(32'(len), 32'(rows[i].base) + 32'h1 + 32'(d[15:8]));
			check({d[15:8] == 8'h0, d[2:0]}, {rows[i].dly == 4'h0, 3'h1});
		end
		// Hold is ignored while arbitration is off.
		hold_want <= 1'h1;
		repeat (10) @(posedge ref_clk);
		check(release_acknowledge_n, 1'h1);
		// The reference clock output must toggle on every rising ref_clk edge.
		d = {31'h0, bus_reference_clock_out};
		@(posedge ref_clk);
		check(bus_reference_clock_out, !d[0]);
		hold_want <= 1'h0;
		repeat (4) @(posedge ref_clk);
		{act_high, dly} <= {1'h1, 4'h0};
		axi_wr(CTRL_OFFSET, 32'h0070_010d, RESP_OKAY);
		fork
			bus_cyc(1'h1);
			begin
				repeat (3) @(posedge ref_clk);
				hold_want <= 1'h1;
			end
		join
		check(32'(len), 32'hb);
		wait_ack(1'h0);
		check({rd_w, wr_w, ale, bus_regain_request_n}, 4'hd);
		@(posedge ref_clk);
		hold_want <= 1'h0;
		wait_ack(1'h1);
		@(posedge ref_clk);
		hold_want <= 1'h1;
		wait_ack(1'h0);
		fork
			bus_cyc(1'h0);
			begin
				repeat (6) @(posedge ref_clk);
				check({bus_regain_request_n, cyc_done}, 2'h0);
				hold_want <= 1'h0;
			end
		join
		check(release_acknowledge_n, 1'h1);
		finish_test;
	end
endmodule
`default_nettype wire
